// *** bench/pfcps_afe_model.sv ***
// front end stand-in: converter answers and switching cycle ticks
`timescale 1ns/1ps
module pfcps_afe_model #(
  parameter int ADC_LAT = 8,
  parameter int PERIOD = 16
) (
  // clock
  input wire logic i_clk,
  // design side
  input wire pfcps_pkg::pfcps_afe_t i_afe,
  input wire logic [11:0] i_scale,
  output logic o_adc_done,
  output logic [11:0] o_adc_mv,
  output logic o_cycle_end,
  output logic [9:0] o_wind_pri,
  output logic [9:0] o_wind_sec
);
  import pfcps_pkg::*;
  int wait_q = 0;
  int tick_q = 0;
  logic [19:0] mv_w;
  assign mv_w = 20'(i_afe.isrc_code) * 20'(i_scale);
  initial begin
    o_adc_done = 1'b0;
    o_adc_mv = 12'h0;
    o_cycle_end = 1'b0;
    o_wind_pri = 10'h0;
    o_wind_sec = 10'h0;
  end
  // results are only held with their strobe, otherwise toggled
  always @(posedge i_clk) begin
    tick_q <= (tick_q == PERIOD - 1) ? 0 : tick_q + 1;
    o_cycle_end <= (tick_q == PERIOD - 1);
    o_wind_pri <= (tick_q == PERIOD - 1) ? 10'h020 : ~o_wind_pri;
    o_wind_sec <= (tick_q == PERIOD - 1) ? 10'h020 : ~o_wind_sec;
    o_adc_done <= (wait_q == 1);
    o_adc_mv <= (wait_q != 1) ? ~o_adc_mv : (mv_w > 20'hfff ? 12'hfff : mv_w[11:0]);
    wait_q <= i_afe.adc_start ? ADC_LAT : (wait_q != 0 ? wait_q - 1 : 0);
  end
endmodule // pfcps_afe_model

// *** bench/pfcps_props.sv ***
// port assertions for the protection sequencer
`timescale 1ns/1ps
module pfcps_props (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // front end and power stage
  input wire pfcps_pkg::pfcps_flags_t i_flags,
  input wire pfcps_pkg::pfcps_afe_t o_afe,
  input wire logic o_switch_en,
  input wire logic o_cycle_kill,
  input wire logic o_ext_otp
);
  import pfcps_pkg::*;
  logic [15:0] settle_q;
  logic [13:0] rp_q;
  logic [5:0] ocp_q;
  // saturating, so a stuck source never wraps into a false pass
  always_ff @(posedge i_clk) begin
    settle_q <= (!i_rst_n || !o_afe.isrc_on) ? 16'h0 : settle_q + {15'h0, settle_q != 16'hffff};
  end
  always_ff @(posedge i_clk) begin
    rp_q <= (!i_rst_n || !o_afe.rpulse_on) ? 14'h0 : rp_q + {13'h0, rp_q != 14'h3fff};
  end
  always_ff @(posedge i_clk) begin
    ocp_q <= (!i_rst_n || i_flags.cur_ocp) ? 6'h0 : ocp_q + {5'h0, ocp_q != 6'h3f};
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  apb_ready_a: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready low in access");
  unmapped_err_a: assert property (i_psel && i_penable && i_paddr > 12'h018 |-> o_pslverr)
    else $error("no error on unmapped access");
  divider_off_a: assert property (o_afe.isrc_on |-> !o_afe.divider_on)
    else $error("divider attached while sourcing");
  settle_wait_a: assert property (o_afe.adc_start |-> o_afe.isrc_on && settle_q >= 16'd17490)
    else $error("conversion before settling");
  // pin flop, gate flop and output flop: three edges before the output follows
  start_gate_a: assert property (!i_flags.boost_start [*4] |-> !o_switch_en)
    else $error("switching below start level");
  ovp_gate_a: assert property (i_flags.boost_ovp [*4] |-> !o_switch_en)
    else $error("switching during output overvoltage");
  pulse_level_a: assert property (o_afe.rpulse_on |-> o_afe.rpulse_mv == 12'd2000)
    else $error("reset pulse amplitude wrong");
  pulse_len_a: assert property (rp_q <= 14'd10000)
    else $error("reset pulse too long");
  kill_cause_a: assert property ($rose(o_cycle_kill) |-> ocp_q < 6'd40)
    else $error("cycle kill without overcurrent");
  reset_quiet_a: assert property (@(posedge i_clk) disable iff (1'b0)
    !i_rst_n |=> !o_switch_en && !o_ext_otp)
    else $error("outputs active in reset");
  cover property (o_afe.adc_start);
  cover property (o_afe.rpulse_on);
  cover property ($fell(o_switch_en));
endmodule // pfcps_props
bind pfcps_top pfcps_props pfcps_props_inst (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_paddr, .o_pready,
  .o_pslverr, .i_flags, .o_afe, .o_switch_en, .o_cycle_kill, .o_ext_otp);

// *** bench/pfcps_top_tb.sv ***
// self-checking bench for the protection sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
`define WAITV(s, v, lim) \
  n = 0; \
  while ((s) !== (v) && n < (lim)) begin \
    @(posedge clk); \
    n++; \
  end
module pfcps_top_tb;
  import pfcps_pkg::*;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} pfcps_row_t;
  pfcps_row_t rows [7] = '{'{12'h000, 32'h01000001, 1'b0}, '{12'h004, 32'h0000803d, 1'b0},
    '{12'h008, 32'h0a082424, 1'b0}, '{12'h00c, 32'h0, 1'b0}, '{12'h010, 32'h0, 1'b0},
    '{12'h018, 32'h00030258, 1'b0}, '{12'h01c, 32'h0, 1'b1}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, adc_done, cyc_end, sw_en, kill, otp;
  logic kill_seen = 1'b0;
  pfcps_flags_t flags = 15'h0;
  pfcps_afe_t afe;
  logic [11:0] adc_mv;
  logic [11:0] scale = 12'd40;
  logic [9:0] wp, ws;
  logic [7:0] c0, c1;
  int compares = 0, err_total = 0, cyc = 0, n;
  pfcps_top #(.RESTART_MS_DEF(600), .FLR_MS_DEF(3), .CNT_RST_CYC(1000), .NOAC_CYC(200), .MS_CYC(10))
    pfcps_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_flags(flags), .i_adc_done(adc_done), .i_adc_mv(adc_mv), .i_cycle_end(cyc_end), .i_wind_pri(wp),
    .i_wind_sec(ws), .o_afe(afe), .o_switch_en(sw_en), .o_cycle_kill(kill), .o_ext_otp(otp));
  pfcps_afe_model pfcps_afe_model_inst (.i_clk(clk), .i_afe(afe), .i_scale(scale), .o_adc_done(adc_done),
    .o_adc_mv(adc_mv), .o_cycle_end(cyc_end), .o_wind_pri(wp), .o_wind_sec(ws));
  always #10 clk = ~clk;
  always @(posedge clk) if (kill === 1'b1) kill_seen <= 1'b1;
  always @(posedge clk) begin
    cyc++;
    // tests take about 87k cycles, mostly thermistor settling
    if (cyc == 95000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // an idle cycle first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one thermistor reading started by a mains peak
  task automatic measure(input logic lp, input int settle, input logic [11:0] sc);
    c0 = afe.isrc_code;
    flags.low_power <= lp;
    scale <= sc;
    flags.line_peak <= 1'b1;
    @(posedge clk);
    flags.line_peak <= 1'b0;
    `WAITV(afe.adc_start, 1'b1, 30000)
    `CHK(n >= settle - 2 && n <= settle + 4, 1'b1)
    `CHK({afe.divider_on, afe.isrc_on}, 2'b01)
    repeat (20) @(posedge clk);
    c1 = afe.isrc_code;
  endtask
  initial begin
    flags.boost_start <= 1'b1;
    flags.boost_below_reg <= 1'b1;
    flags.line_above_bi <= 1'b1;
    flags.ac_present <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK({afe.divider_on, afe.isrc_code, sw_en}, 10'h220)
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      `CHK(e, rows[i].e)
      if (!rows[i].e) `CHK(q, rows[i].d)
    end
    $display("register table done");
    apb(1'b1, 12'h000, 32'hffff0001);
    measure(1'b0, 17500, 12'd40);
    `CHK(c1 > c0, 1'b1)
    measure(1'b1, 22500, 12'd200);
    `CHK(c1 < c0, 1'b1)
    measure(1'b0, 17500, 12'(1700 / c1));
    `CHK(c1, c0)
    `CHK(otp, 1'b0)
    $display("thermistor search done");
    flags.cur_ocp <= 1'b1;
    @(posedge clk);
    flags.cur_ocp <= 1'b0;
    repeat (40) @(posedge clk);
    `CHK(kill_seen, 1'b0)
    flags.cur_ocp <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(kill, 1'b1)
    flags.cur_ocp <= 1'b0;
    `WAITV(kill, 1'b0, 60)
    `CHK(kill, 1'b0)
    $display("overcurrent done");
    apb(1'b1, 12'h018, 32'h00030064);
    apb(1'b0, 12'h018, 32'h0);
    `CHK(q, 32'h000301f4)
    apb(1'b1, 12'h004, 32'h00008039);
    flags.cur_ocp <= 1'b1;
    repeat (490) @(posedge cyc_end);
    apb(1'b0, 12'h010, 32'h0);
    `CHK(q[3], 1'b0)
    repeat (20) @(posedge cyc_end);
    apb(1'b0, 12'h010, 32'h0);
    `CHK({q[3], sw_en}, 2'b10)
    flags.cur_ocp <= 1'b0;
    repeat (5500) @(posedge clk);
    `CHK(sw_en, 1'b0)
    $display("coil short latch done");
    apb(1'b1, 12'h000, 32'hffff0003);
    flags.line_below_bo <= 1'b1;
    flags.line_above_bi <= 1'b0;
    repeat (100) @(posedge clk);
    flags.line_below_bo <= 1'b0;
    flags.line_above_bi <= 1'b1;
    `WAITV(afe.rpulse_on, 1'b1, 20000)
    `WAITV(afe.rpulse_on, 1'b0, 12000)
    `CHK(n, 10000)
    `WAITV(sw_en, 1'b1, 20000)
    `CHK(sw_en, 1'b1)
    apb(1'b1, 12'h010, 32'h000007ff);
    apb(1'b0, 12'h010, 32'h0);
    `CHK(q[10:0], 11'h0)
    $display("fast latch reset done");
    flags.boost_ovp <= 1'b1;
    flags.boost_below_reg <= 1'b0;
    repeat (10) @(posedge clk);
    flags.boost_ovp <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(sw_en, 1'b0)
    flags.boost_below_reg <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK(sw_en, 1'b1)
    $display("output overvoltage done");
    flags.boost_start <= 1'b0;
    repeat (20) @(posedge clk);
    flags.boost_start <= 1'b1;
    `WAITV(sw_en, 1'b1, 8000)
    `CHK(n >= 4975 && n <= 5010, 1'b1)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(q[0], 1'b1)
    $display("fast disable restart done");
    apb(1'b1, 12'h010, 32'h000007ff);
    flags.phase_dev <= 1'b1;
    flags.line_ovp <= 1'b1;
    @(posedge clk);
    flags.phase_dev <= 1'b0;
    flags.line_ovp <= 1'b0;
    apb(1'b0, 12'h010, 32'h0);
    `CHK(q[5], 1'b1)
    `CHK(q[6], 1'b1)
    `CHK(sw_en, 1'b0)
    apb(1'b1, 12'h000, 32'h01000001);
    repeat (50) @(posedge clk);
    `CHK(otp, 1'b0)
    repeat (100) @(posedge clk);
    `CHK(otp, 1'b1)
    $display("phase, mains and temperature trips done");
    stop_test();
  end
endmodule // pfcps_top_tb

// *** verilog/pfcps_params.svh ***
// constants for the protection sequencer
`ifndef PFCPS_PARAMS_SVH
`define PFCPS_PARAMS_SVH
`define PFCPS_CLK_HZ 50000000
`define PFCPS_SETTLE_NORM_US 350
`define PFCPS_SETTLE_LP_US 450
`define PFCPS_NOAC_PERIOD_MS 100
`define PFCPS_CNT_RST_S 65
`define PFCPS_RPULSE_US 200
`define PFCPS_RPULSE_MV 2000
`define PFCPS_WIN_LO_MV 1100
`define PFCPS_WIN_HI_MV 2400
`define PFCPS_RESTART_MIN_MS 500
`define PFCPS_RESTART_MAX_MS 10000
`define PFCPS_ADDR_CTRL 12'h000
`define PFCPS_ADDR_CFG 12'h004
`define PFCPS_ADDR_LIMITS 12'h008
`define PFCPS_ADDR_STATUS 12'h00c
`define PFCPS_ADDR_PROT 12'h010
`define PFCPS_ADDR_NTC 12'h014
`define PFCPS_ADDR_TIMES 12'h018
`define PFCPS_ISRC_RST 8'h10
`define PFCPS_OVP_LVL_RST 8'h80
`define PFCPS_GMAX_RST 16'h0100
`endif

// *** verilog/pfcps_pkg.sv ***
// types for the protection sequencer
package pfcps_pkg;
  typedef enum logic [1:0] {
    PFCPS_RESP_STOP, PFCPS_RESP_RESTART, PFCPS_RESP_LATCH, PFCPS_RESP_LATCH_AFTER
  } pfcps_resp_t;
  typedef struct packed {
    logic boost_start;
    logic boost_open;
    logic boost_ovp;
    logic boost_below_reg;
    logic cur_ocp;
    logic src_ocp;
    logic line_ovp;
    logic line_below_bo;
    logic line_above_bi;
    logic line_peak;
    logic ac_present;
    logic sense_dev;
    logic cur_above_min;
    logic phase_dev;
    logic low_power;
  } pfcps_flags_t;
  typedef struct packed {
    logic divider_on;
    logic isrc_on;
    logic [7:0] isrc_code;
    logic adc_start;
    logic rpulse_on;
    logic [11:0] rpulse_mv;
  } pfcps_afe_t;
endpackage

// *** verilog/pfcps_top.sv ***
// protection sequencer: thermistor search, fault detectors, response logic, apb registers
// What this block does
// RQ1: detach divider, source current, settle, convert
// RQ2: step thermistor current toward voltage window
// RQ3: overtemperature only after persistent configured delay
// RQ4: measure at mains peak, else periodically
// RQ5: longer settling time in low-power mode
// RQ6: no switching before start level, open, short
// RQ7: fast disable: stop or protect by configuration
// RQ8: output overvoltage inhibits until below regulation
// RQ9: winding current sum overvoltage for n cycles
// RQ10: overcurrent ends cycle, blocks inrush turn-on
// RQ11: filter overcurrent against turn-on spikes
// RQ12: sense resistor short on deviation, current, cycles
// RQ13: continuous cycle overcurrent counts to coil short
// RQ14: continuous source overcurrent counts to diode short
// RQ15: phase deviation above threshold trips protection
// RQ16: mains overvoltage may suspend operation
// RQ17: latched stays stopped until fast reset
// RQ18: safe restart after one shared delay
// RQ19: retry counter latches, clears after quiet interval
// RQ20: long brownout clears latched protection
// RQ21: optional fixed reset pulse after brownin
// RQ22: restart delay configurable half to ten seconds
// RQ23: selectable detector cycle limits, each disableable
// RQ24: record tripped protections, readable and clearable
// RQ25: clean cycle resets overcurrent counters
// RQ26: comparator flags sampled on internal clock
`timescale 1ns/1ps
`include "pfcps_params.svh"
module pfcps_top #(
  parameter int RESTART_MS_DEF = 1000,
  parameter int FLR_MS_DEF = 1000,
  parameter longint CNT_RST_CYC = longint'(`PFCPS_CNT_RST_S) * `PFCPS_CLK_HZ,
  parameter int NOAC_CYC = `PFCPS_NOAC_PERIOD_MS * (`PFCPS_CLK_HZ / 1000),
  parameter int MS_CYC = `PFCPS_CLK_HZ / 1000,
  parameter int OCP_FILT = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // analog front end
  input wire pfcps_pkg::pfcps_flags_t i_flags,
  input wire logic i_adc_done,
  input wire logic [11:0] i_adc_mv,
  input wire logic i_cycle_end,
  input wire logic [9:0] i_wind_pri,
  input wire logic [9:0] i_wind_sec,
  output pfcps_pkg::pfcps_afe_t o_afe,
  // power stage
  output logic o_switch_en,
  output logic o_cycle_kill,
  output logic o_ext_otp
);
  import pfcps_pkg::*;

  localparam int SETTLE_N = (`PFCPS_SETTLE_NORM_US * (`PFCPS_CLK_HZ / 1000000));
  localparam int SETTLE_L = (`PFCPS_SETTLE_LP_US * (`PFCPS_CLK_HZ / 1000000));
  localparam int RPULSE_CYC = (`PFCPS_RPULSE_US * (`PFCPS_CLK_HZ / 1000000));

  // quiet interval counter is 32 bits wide
  if (OCP_FILT < 2 || OCP_FILT > 255 || MS_CYC < 1 || NOAC_CYC < 1 || CNT_RST_CYC < 1 ||
      CNT_RST_CYC > 64'h0000_0000_ffff_ffff) begin : g_bad_param
    $error("pfcps_top: bad parameter");
  end

  // sampled comparator flags
  pfcps_flags_t fl_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) fl_q <= '0;
    else fl_q <= i_flags; // see RQ26
  end

  // registers
  logic [31:0] ctrl_q, cfg_q, lim_q, times_q;
  logic [10:0] prot_q;
  logic [10:0] trip;
  logic [7:0] isrc_q;
  logic [11:0] ntc_mv_q;
  logic wr, rd_ok;
  logic prot_idle, run_q;
  logic [15:0] rp_cnt_q;
  assign wr = i_psel && i_penable && i_pwrite;
  assign o_pready = 1'b1;
  // ctrl: [0] enable [1] reset pulse option [2] lp settle force
  // cfg: [1:0] fast disable resp, [3:2] fault resp, [7:4] retry count, [15:8] winding ovp level
  // lim: [1:0] coil lim sel [2] coil en [4:3] diode lim sel [5] diode en, [15:8] aux cycles,
  //      [23:16] sense short cycles, [31:24] otp delay ms
  // times: [15:0] restart ms, [31:16] flr ms; gmax in ntc high half of ctrl
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= {`PFCPS_GMAX_RST, 16'h0001};
      cfg_q <= {16'h0000, `PFCPS_OVP_LVL_RST, 8'h3d};
      lim_q <= 32'h0a08_2424;
      times_q <= {FLR_MS_DEF[15:0], RESTART_MS_DEF[15:0]};
    end else if (wr) begin
      case (i_paddr)
        `PFCPS_ADDR_CTRL: ctrl_q <= i_pwdata;
        `PFCPS_ADDR_CFG: cfg_q <= i_pwdata;
        `PFCPS_ADDR_LIMITS: lim_q <= i_pwdata;
        `PFCPS_ADDR_TIMES: begin
          // clamp the shared restart delay into its range
          if (i_pwdata[15:0] < 16'(`PFCPS_RESTART_MIN_MS)) times_q <= {i_pwdata[31:16], 16'(`PFCPS_RESTART_MIN_MS)}; // see RQ22
          else if (i_pwdata[15:0] > 16'(`PFCPS_RESTART_MAX_MS)) times_q <= {i_pwdata[31:16], 16'(`PFCPS_RESTART_MAX_MS)}; // see RQ22
          else times_q <= i_pwdata;
        end
        default: ;
      endcase
    end
  end
  always_comb begin
    rd_ok = 1'b1;
    case (i_paddr)
      `PFCPS_ADDR_CTRL: o_prdata = ctrl_q;
      `PFCPS_ADDR_CFG: o_prdata = cfg_q;
      `PFCPS_ADDR_LIMITS: o_prdata = lim_q;
      `PFCPS_ADDR_PROT: o_prdata = {21'h0, prot_q};
      `PFCPS_ADDR_NTC: o_prdata = {12'h0, isrc_q, ntc_mv_q};
      `PFCPS_ADDR_TIMES: o_prdata = times_q;
      `PFCPS_ADDR_STATUS: o_prdata = 32'h0;
      default: begin
        o_prdata = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end
  assign o_pslverr = i_psel && i_penable && !rd_ok;

  function automatic logic [13:0] lim_cycles(input logic [1:0] sel);
    case (sel)
      2'd0: lim_cycles = 14'd500;
      2'd1: lim_cycles = 14'd2500;
      2'd2: lim_cycles = 14'd5000;
      default: lim_cycles = 14'd12500;
    endcase
  endfunction

  // millisecond tick
  logic [31:0] ms_cnt_q;
  logic ms_tick;
  assign ms_tick = (ms_cnt_q == 32'(MS_CYC - 1));
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || ms_tick) ms_cnt_q <= '0;
    else ms_cnt_q <= ms_cnt_q + 32'd1;
  end

  // thermistor measurement sequencer
  typedef enum logic [1:0] {NT_IDLE, NT_SETTLE, NT_CONV} pfcps_nt_t;
  pfcps_nt_t nt_q;
  logic [31:0] nt_cnt_q, per_q;
  logic nt_req, otp_now;
  assign nt_req = fl_q.ac_present ? fl_q.line_peak : (per_q == 32'(NOAC_CYC - 1)); // see RQ4
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || fl_q.ac_present || per_q == 32'(NOAC_CYC - 1)) per_q <= '0;
    else per_q <= per_q + 32'd1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      nt_q <= NT_IDLE;
      nt_cnt_q <= '0;
    end else begin
      case (nt_q)
        NT_IDLE: if (nt_req) begin
          nt_q <= NT_SETTLE; // see RQ1
          nt_cnt_q <= (fl_q.low_power || ctrl_q[2]) ? 32'(SETTLE_L) : 32'(SETTLE_N); // see RQ5
        end
        NT_SETTLE: begin
          if (nt_cnt_q <= 32'd1) nt_q <= NT_CONV;
          nt_cnt_q <= nt_cnt_q - 32'd1;
        end
        NT_CONV: if (i_adc_done) nt_q <= NT_IDLE;
        default: nt_q <= NT_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_afe <= '{divider_on: 1'b1, isrc_on: 1'b0, isrc_code: `PFCPS_ISRC_RST, adc_start: 1'b0,
                 rpulse_on: 1'b0, rpulse_mv: 12'h0};
    end else begin
      o_afe.divider_on <= (nt_q == NT_IDLE) && !nt_req; // see RQ1
      o_afe.isrc_on <= (nt_q != NT_IDLE); // see RQ1
      o_afe.isrc_code <= isrc_q;
      o_afe.adc_start <= (nt_q == NT_SETTLE) && (nt_cnt_q <= 32'd1); // see RQ1
      o_afe.rpulse_on <= rp_cnt_q != '0;
      o_afe.rpulse_mv <= (rp_cnt_q != '0) ? 12'(`PFCPS_RPULSE_MV) : 12'h0;
    end
  end
  // current search; conductance ~ current code / voltage
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      isrc_q <= `PFCPS_ISRC_RST;
      ntc_mv_q <= '0;
    end else if (nt_q == NT_CONV && i_adc_done) begin
      ntc_mv_q <= i_adc_mv;
      if (i_adc_mv < 12'(`PFCPS_WIN_LO_MV) && isrc_q != 8'hff) isrc_q <= isrc_q + 8'd1; // see RQ2
      else if (i_adc_mv > 12'(`PFCPS_WIN_HI_MV) && isrc_q != 8'h00) isrc_q <= isrc_q - 8'd1; // see RQ2
    end
  end
  // otp only judged on an in-window reading: i*k > gmax*v
  assign otp_now = (ntc_mv_q >= 12'(`PFCPS_WIN_LO_MV)) && (ntc_mv_q <= 12'(`PFCPS_WIN_HI_MV)) &&
                   ({8'h00, isrc_q, 12'h000} > ((28'(ctrl_q[31:16]) * 28'(ntc_mv_q)) >> 4)); // see RQ3
  logic [7:0] otp_ms_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !otp_now) otp_ms_q <= '0;
    else if (ms_tick && otp_ms_q != 8'hff) otp_ms_q <= otp_ms_q + 8'd1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) o_ext_otp <= 1'b0;
    else o_ext_otp <= otp_now && (otp_ms_q >= lim_q[31:24]); // see RQ3
  end

  // cycle overcurrent filter against turn-on ringing
  logic [7:0] ocp_f_q;
  logic ocp_filt;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !fl_q.cur_ocp) ocp_f_q <= '0;
    else if (ocp_f_q != 8'(OCP_FILT)) ocp_f_q <= ocp_f_q + 8'd1; // see RQ11
  end
  assign ocp_filt = (ocp_f_q == 8'(OCP_FILT));
  logic ocp_seen_q, src_seen_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ocp_seen_q <= 1'b0;
      src_seen_q <= 1'b0;
      o_cycle_kill <= 1'b0;
    end else begin
      // kill held until a cycle boundary with the flag gone, also during inrush
      if (ocp_filt) o_cycle_kill <= 1'b1; // see RQ10
      else if (i_cycle_end) o_cycle_kill <= 1'b0; // see RQ10
      ocp_seen_q <= i_cycle_end ? ocp_filt : (ocp_seen_q || ocp_filt);
      src_seen_q <= i_cycle_end ? fl_q.src_ocp : (src_seen_q || fl_q.src_ocp);
    end
  end

  // per-cycle fault counters
  logic [13:0] coil_q, diode_q;
  logic [7:0] aux_q, ssc_q;
  logic [10:0] wsum;
  // carry kept, a wrapped sum would hide an overvoltage
  assign wsum = 11'(i_wind_pri) + 11'(i_wind_sec); // see RQ9
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !prot_idle) begin
      coil_q <= '0;
      diode_q <= '0;
      aux_q <= '0;
      ssc_q <= '0;
    end else if (i_cycle_end) begin
      coil_q <= (ocp_seen_q || ocp_filt) ? coil_q + 14'd1 : 14'd0; // see RQ13 RQ25
      diode_q <= (src_seen_q || fl_q.src_ocp) ? diode_q + 14'd1 : 14'd0; // see RQ14 RQ25
      aux_q <= (wsum > {3'b000, cfg_q[15:8]}) ? aux_q + 8'd1 : 8'd0; // see RQ9
      ssc_q <= (fl_q.sense_dev && fl_q.cur_above_min) ? ssc_q + 8'd1 : 8'd0; // see RQ12
    end
  end
  // trip order: 0 fastdis 1 aux 2 sense 3 coil 4 diode 5 phase 6 line ovp 7 otp
  assign trip[0] = !fl_q.boost_start && cfg_q[1:0] != PFCPS_RESP_STOP && run_q; // see RQ7
  assign trip[1] = aux_q >= lim_q[15:8] && lim_q[15:8] != 8'h0; // see RQ9
  assign trip[2] = ssc_q >= lim_q[23:16] && lim_q[23:16] != 8'h0; // see RQ12
  assign trip[3] = lim_q[2] && coil_q >= lim_cycles(lim_q[1:0]); // see RQ13 RQ23
  assign trip[4] = lim_q[5] && diode_q >= lim_cycles(lim_q[4:3]); // see RQ14 RQ23
  assign trip[5] = fl_q.phase_dev; // see RQ15
  assign trip[6] = fl_q.line_ovp; // see RQ16
  assign trip[7] = o_ext_otp;
  assign trip[10:8] = 3'b000;

  // response machine
  typedef enum logic [1:0] {PR_RUN, PR_WAIT, PR_LATCH} pfcps_pr_t;
  pfcps_pr_t pr_q;
  logic any_trip, ovp_inh_q;
  logic [15:0] pr_ms_q, bo_ms_q;
  logic [3:0] retry_q;
  logic [31:0] quiet_q;
  logic [1:0] resp;
  assign prot_idle = (pr_q == PR_RUN);
  assign any_trip = |trip;
  assign resp = trip[0] ? cfg_q[1:0] : cfg_q[3:2];
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pr_q <= PR_RUN;
      pr_ms_q <= '0;
      retry_q <= '0;
    end else begin
      case (pr_q)
        PR_RUN: if (any_trip && ctrl_q[0]) begin
          pr_ms_q <= '0;
          if (resp == PFCPS_RESP_LATCH) pr_q <= PR_LATCH; // see RQ17
          else if (resp == PFCPS_RESP_LATCH_AFTER && retry_q + 4'd1 >= cfg_q[7:4]) pr_q <= PR_LATCH; // see RQ19
          else pr_q <= PR_WAIT; // see RQ18
          if (resp == PFCPS_RESP_LATCH_AFTER) retry_q <= retry_q + 4'd1; // see RQ19
        end else if (quiet_q == 32'(CNT_RST_CYC - 1)) retry_q <= '0; // see RQ19
        PR_WAIT: begin
          if (ms_tick) pr_ms_q <= pr_ms_q + 16'd1;
          if (pr_ms_q >= times_q[15:0]) pr_q <= PR_RUN; // see RQ18
        end
        PR_LATCH: if (bo_ms_q >= times_q[31:16] && fl_q.line_below_bo) pr_q <= PR_RUN; // see RQ17 RQ20
        default: pr_q <= PR_RUN;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !prot_idle || any_trip || quiet_q == 32'(CNT_RST_CYC - 1)) quiet_q <= '0;
    else quiet_q <= quiet_q + 32'd1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !fl_q.line_below_bo) bo_ms_q <= '0;
    else if (ms_tick && bo_ms_q != 16'hffff) bo_ms_q <= bo_ms_q + 16'd1; // see RQ20
  end
  // protection record: set wins over software clear (write one to clear)
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) prot_q <= '0;
    else prot_q <= (wr && i_paddr == `PFCPS_ADDR_PROT ? prot_q & ~i_pwdata[10:0] : prot_q)
                   | (prot_idle && ctrl_q[0] ? trip : 11'h0); // see RQ24
  end

  // switching gate
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) ovp_inh_q <= 1'b0;
    else if (fl_q.boost_ovp) ovp_inh_q <= 1'b1; // see RQ8
    else if (fl_q.boost_below_reg) ovp_inh_q <= 1'b0; // see RQ8
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) run_q <= 1'b0;
    else run_q <= fl_q.boost_start && !fl_q.boost_open; // see RQ6 RQ7
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) o_switch_en <= 1'b0;
    else o_switch_en <= ctrl_q[0] && prot_idle && run_q && !ovp_inh_q && !any_trip; // see RQ6 RQ8
  end

  // downstream reset pulse after a fast latch reset brownout then brownin
  logic flr_arm_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flr_arm_q <= 1'b0;
      rp_cnt_q <= '0;
    end else begin
      if (ctrl_q[1] && fl_q.line_below_bo && bo_ms_q >= times_q[31:16]) flr_arm_q <= 1'b1; // see RQ21
      else if (flr_arm_q && fl_q.line_above_bi) begin
        flr_arm_q <= 1'b0;
        rp_cnt_q <= 16'(RPULSE_CYC); // see RQ21
      end
      if (rp_cnt_q != '0 && !(flr_arm_q && fl_q.line_above_bi)) rp_cnt_q <= rp_cnt_q - 16'd1;
    end
  end
endmodule // pfcps_top
